// >>> bench/dih_field_model.sv
// Field switch model driving the handler's input pins
`timescale 1ns/1ps
module dih_field_model (
    input wire logic i_core_clk,
    input wire logic [15:0] i_closed,
    output logic [15:0] o_pins
);
    // ********
    // Contacts
    // ********
    // A closed contact pulls the pin to common and reads ON; an open one reads OFF.
    // Contacts move on the clock, unrelated in phase to the scan tick.
    always_ff @(posedge i_core_clk) begin
        o_pins <= i_closed;
    end
endmodule

// >>> bench/dih_top_props.sv
// Concurrent checks on the handler's top ports
`timescale 1ns/1ps
`include "dih_defs.svh"
module dih_top_props (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_prog_running,
    input wire logic i_motion_stopped,
    input wire logic i_assign_enable,
    input wire logic i_prog_run_out_assigned,
    input wire logic [`DIH_NUM_IN-1:0] o_input_flags,
    input wire logic o_drive_enabled,
    input wire logic o_enable_seq,
    input wire logic o_disable_seq,
    input wire logic o_abort_prog,
    input wire logic o_start_prog,
    input wire logic [7:0] o_start_prog_num,
    input wire logic o_prog_running_out
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ********
    // Checks
    // ********
    chk_start_num_known: assert property (
        o_start_prog |-> o_start_prog_num inside {`DIH_PROG_HOME, `DIH_PROG_EMERG})
        else $error("unknown program started");
    chk_emerg_after_stop: assert property (
        o_start_prog && o_start_prog_num == `DIH_PROG_EMERG |-> $past(i_motion_stopped))
        else $error("emergency program before standstill");
    chk_home_refused: assert property (
        o_start_prog && o_start_prog_num == `DIH_PROG_HOME |-> !$past(i_prog_running))
        else $error("home started over a running program");
    chk_disable_drops: assert property (
        o_disable_seq |=> !o_drive_enabled)
        else $error("still enabled after disable");
    chk_enable_raises: assert property (
        o_enable_seq && !o_disable_seq |=> o_drive_enabled)
        else $error("not enabled after enable");
    chk_run_out_drops: assert property (
        o_disable_seq && i_assign_enable && i_prog_run_out_assigned |-> ##[1:2] !o_prog_running_out)
        else $error("running output kept after enable drop");
    chk_abort_on_fall: assert property (
        o_disable_seq && i_assign_enable && i_prog_running |-> ##[1:2] o_abort_prog)
        else $error("no abort on enable drop");
    chk_flags_hold: assert property (
        $changed(o_input_flags) |=> $stable(o_input_flags) [*8])
        else $error("flags moved between scans");
    cover property (o_start_prog && o_start_prog_num == `DIH_PROG_HOME);
    cover property (o_start_prog && o_start_prog_num == `DIH_PROG_EMERG);
    cover property (o_disable_seq && i_prog_running);
endmodule
bind dih_top dih_top_props u_props (.*);

// >>> bench/tb_top.sv
// Self-checking bench for the discrete input function handler
`timescale 1ns/1ps
`include "dih_defs.svh"
module tb_top;
    // Short scan keeps the run brief; the scan and edge logic is the same
    localparam int SCAN = 32;
    logic [15:0] closed = 16'h0000, i_out_default_en = 16'h00FF, i_out_default_val = 16'h0055;
    logic [15:0] i_prog_out_value = 16'h0000, i_jog_vel_wdata = 16'h0000, rnd;
    logic [15:0] i_jog_vel_param = 16'h0040, i_jog_acceleration = 16'h0040;
    logic [15:0] i_jog_deceleration = 16'h0020, i_in_pins, o_input_flags;
    logic [15:0] o_out_pull_low, o_jog_velocity;
    logic [7:0] i_debounce_ticks = 8'h02, o_start_prog_num;
    logic [3:0] i_test_sel = 4'h0;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_assign_enable = 1'b0, i_assign_emerg = 1'b1;
    logic i_assign_home_cmd = 1'b1, i_assign_home_sw = 1'b1, i_assign_jog = 1'b1;
    logic i_home_sw_active_open = 1'b1, i_prog_run_out_assigned = 1'b1, i_prog_out_we = 1'b0;
    logic i_enable_cmd = 1'b0, i_disable_cmd = 1'b0, i_prog_running = 1'b0, i_prog_start = 1'b0;
    logic i_motion_stopped = 1'b0, i_jog_vel_we = 1'b0, i_cv_move_active = 1'b0;
    logic i_cv_move_rev = 1'b0, o_test_result, o_drive_enabled, o_enable_seq, o_disable_seq;
    logic o_abort_prog, o_start_prog, o_home_switch_active, o_prog_running_out, o_cv_move_hold;
    logic signed [16:0] o_jog_cmd_vel;
    logic [7:0] exp_q[$];
    int fails = 0, n_checks = 0, k;
    integer seed = 32'hd27b;

    dih_field_model u_field (.i_core_clk(i_core_clk), .i_closed(closed), .o_pins(i_in_pins));
    dih_top #(.SCAN_CYCLES(SCAN)) u_dut (.*);

    // ********
    // Helpers
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // A wait that ran out is a mismatch and ends the run
    task automatic timed(input int lim);
        if (k >= lim) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, k, lim);
            report_and_stop();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    // Every program start must match the oldest note; none noted means none allowed
    always @(posedge i_core_clk) begin
        if (i_rst_b && o_start_prog) begin
            if (exp_q.size() > 0) begin
                check(o_start_prog_num, exp_q.pop_front());
            end else begin
                check(o_start_prog_num, 8'h00);
            end
        end
    end

    initial begin
        cyc(12);
        i_rst_b <= 1'b1;
        cyc(3);
        check(o_drive_enabled, 1'b1);
        check(o_jog_velocity, i_jog_vel_param);
        check(o_home_switch_active, 1'b1);
        i_home_sw_active_open <= 1'b0;
        rnd = $random(seed);
        i_prog_out_value <= rnd;
        i_prog_out_we <= 1'b1;
        cyc(1);
        i_prog_out_we <= 1'b0;
        cyc(2);
        check(o_home_switch_active, 1'b0);
        check(o_out_pull_low, rnd);
        $display("test reset and outputs done");
        exp_q.push_back(`DIH_PROG_HOME);
        closed <= 16'h0021;
        for (k = 0; k < 2 * SCAN && o_input_flags[5] !== 1'b1; k++)
            cyc(1);
        timed(2 * SCAN);
        cyc(2);
        check(o_input_flags[0], 1'b0);
        check(o_test_result, 1'b0);
        for (k = 0; k < 4 * SCAN && o_input_flags[0] !== 1'b1; k++)
            cyc(1);
        timed(4 * SCAN);
        check(k >= SCAN, 1'b1);
        cyc(3);
        check(o_test_result, 1'b1);
        check(exp_q.size(), 0);
        closed <= 16'h0001;
        i_prog_running <= 1'b1;
        cyc(2 * SCAN);
        closed <= 16'h0021;
        cyc(2 * SCAN);
        check(o_input_flags[5], 1'b1);
        $display("test home command done");
        closed <= 16'h0221;
        for (k = 0; k < 2 * SCAN && o_abort_prog !== 1'b1; k++)
            cyc(1);
        timed(2 * SCAN);
        cyc(20);
        exp_q.push_back(`DIH_PROG_EMERG);
        i_motion_stopped <= 1'b1;
        cyc(5);
        check(exp_q.size(), 0);
        $display("test emergency return done");
        i_assign_enable <= 1'b1;
        closed <= 16'h0025;
        for (k = 0; k < 2 * SCAN && o_enable_seq !== 1'b1; k++)
            cyc(1);
        timed(2 * SCAN);
        closed <= 16'h0021;
        for (k = 0; k < 2 * SCAN && o_disable_seq !== 1'b1; k++)
            cyc(1);
        timed(2 * SCAN);
        // The program engine stops once aborted
        i_prog_running <= 1'b0;
        cyc(1);
        check(o_prog_running_out, 1'b0);
        check(o_abort_prog, 1'b1);
        cyc(3);
        check(o_drive_enabled, 1'b0);
        check(o_out_pull_low & i_out_default_en, i_out_default_val);
        $display("test enable input done");
        i_assign_enable <= 1'b0;
        i_prog_running <= 1'b0;
        i_enable_cmd <= 1'b1;
        i_prog_start <= 1'b1;
        cyc(1);
        i_enable_cmd <= 1'b0;
        i_prog_start <= 1'b0;
        cyc(3);
        check(o_drive_enabled, 1'b1);
        check(o_jog_velocity, 16'h0000);
        rnd = 16'h0041 + ($random(seed) & 16'h001F);
        i_jog_vel_wdata <= rnd;
        i_jog_vel_we <= 1'b1;
        cyc(1);
        i_jog_vel_we <= 1'b0;
        closed <= 16'h0041;
        for (k = 0; k < 8 * SCAN && o_jog_cmd_vel !== {1'b0, rnd}; k++)
            cyc(1);
        timed(8 * SCAN);
        closed <= 16'h0001;
        for (k = 0; k < 8 * SCAN && o_jog_cmd_vel !== 17'h00000; k++)
            cyc(1);
        timed(8 * SCAN);
        i_cv_move_active <= 1'b1;
        closed <= 16'h0081;
        for (k = 0; k < 8 * SCAN && o_jog_cmd_vel !== 17'h00000 - {1'b0, rnd}; k++)
            cyc(1);
        timed(8 * SCAN);
        check(o_cv_move_hold, 1'b1);
        i_cv_move_rev <= 1'b1;
        cyc(3);
        check(o_cv_move_hold, 1'b0);
        i_cv_move_active <= 1'b0;
        cyc(3);
        check(o_jog_velocity, i_jog_vel_param);
        i_disable_cmd <= 1'b1;
        cyc(1);
        i_disable_cmd <= 1'b0;
        cyc(3);
        check(o_drive_enabled, 1'b0);
        $display("test jog done");
        report_and_stop();
    end
endmodule

// >>> verilog/dih_debounce.sv
// Per-input debounce filter, bypassed for assigned inputs
`timescale 1ns/1ps
`include "dih_defs.svh"
module dih_debounce import dih_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [`DIH_NUM_IN-1:0] i_bypass,
    input wire logic [`DIH_DB_W-1:0] i_db_ticks,
    dih_scan_if.filt scan
);
    logic [`DIH_NUM_IN-1:0] flag_ff;
    assign scan.flags = flag_ff;

    genvar g;
    generate
        for (g = 0; g < `DIH_NUM_IN; g = g + 1) begin : g_in
            logic [`DIH_DB_W-1:0] cnt_ff;
            // Updates only on the scan tick (see R4)
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    flag_ff[g] <= 1'b0;
                    cnt_ff <= '0;
                end else if (scan.tick) begin
                    if (i_bypass[g] || scan.raw[g] == flag_ff[g]) begin
                        // Assigned inputs skip filtering (see R7)
                        flag_ff[g] <= scan.raw[g];
                        cnt_ff <= '0;
                    end else if (cnt_ff >= i_db_ticks) begin
                        // Stable long enough (see R6)
                        flag_ff[g] <= scan.raw[g];
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 8'h01;
                    end
                end
            end
        end
    endgenerate
endmodule

// >>> verilog/dih_defs.svh
// Constants for the discrete input function handler
// Operation
// R1: An input reads ON while its pin is pulled to the 24 V common.
// R2: An ON output pulls its pin to common; an OFF output floats.
// R3: All sixteen inputs are usable as general purpose inputs, select lines too.
// R4: Each input is sampled once per 1 ms loop tick into a flag.
// R5: Program input tests read the sampled flag, never the live pin.
// R6: A flag changes only after the input stayed stable for the debounce time.
// R7: Debounce applies to general purpose inputs only; assigned inputs bypass it.
// R8: Each dedicated function can be disabled, returning its pin to general use.
// R9: Unassigned enable input means enabled at power-up, then only by commands.
// R10: Enable input rising edge runs the same sequence as the enable instruction.
// R11: Enable input falling edge runs the disable sequence and aborts any program.
// R12: If a program ran when enable dropped, default-configured outputs take defaults.
// R13: Enable drop clears the program-running output when that output is assigned.
// R14: Emergency return rise aborts the program, waits for standstill, starts program 26.
// R15: Falling edges of emergency return and home command are ignored.
// R16: Home command rising edge starts system program 25, the homing routine.
// R17: A home command rise is discarded while another main program runs.
// R18: Home switch active polarity is configurable as open or closed.
// R19: Jog forward increases position, reverse decreases; speed and ramps from variables.
// R20: Any program start clears the jog velocity to zero.
// R21: When a constant-velocity move finishes at zero, jog velocity reloads from parameter.
// R22: Opposite jog ramps a constant-velocity move to zero; release resumes; same direction ignored.
// R23: While jog is ON ramp to jog velocity at jog acceleration; off ramps down.
// R24: Dedicated input edges are found by comparing consecutive scan samples.
`ifndef DIH_DEFS_SVH
`define DIH_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define DIH_CLK_PERIOD_NS 10
`define DIH_SCAN_PERIOD_US 1000
`define DIH_SCAN_CYCLES ((`DIH_SCAN_PERIOD_US * 1000) / `DIH_CLK_PERIOD_NS)

// ****************************************
// Input positions and sizes
// ****************************************
`define DIH_NUM_IN 16
`define DIH_NUM_OUT 16
`define DIH_IDX_ENABLE 2
`define DIH_IDX_HOME_SW 4
`define DIH_IDX_HOME_CMD 5
`define DIH_IDX_JOG_FWD 6
`define DIH_IDX_JOG_REV 7
`define DIH_IDX_EMERG 9
`define DIH_PROG_HOME 8'h19
`define DIH_PROG_EMERG 8'h1A
`define DIH_VEL_W 16
`define DIH_DB_W 8

`endif

// >>> verilog/dih_jog_ramp.sv
// Jog velocity ramp generator
`timescale 1ns/1ps
`include "dih_defs.svh"
module dih_jog_ramp import dih_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic i_dir_rev,
    input wire logic [`DIH_VEL_W-1:0] i_speed,
    input wire logic [`DIH_VEL_W-1:0] i_accel,
    input wire logic [`DIH_VEL_W-1:0] i_decel,
    output logic [`DIH_VEL_W-1:0] o_mag
);
    logic [`DIH_VEL_W-1:0] mag_ff;
    logic [`DIH_VEL_W:0] up;
    assign o_mag = mag_ff;
    assign up = {1'b0, mag_ff} + {1'b0, i_accel};

    // Ramp up at acceleration while held, down at deceleration after (see R23)
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            mag_ff <= '0;
        end else if (i_tick) begin
            if (i_run) begin
                if (mag_ff > i_speed) begin
                    mag_ff <= (mag_ff - i_speed > i_decel) ? mag_ff - i_decel : i_speed;
                end else begin
                    mag_ff <= (up[`DIH_VEL_W-1:0] > i_speed || up[`DIH_VEL_W]) ?
                              i_speed : up[`DIH_VEL_W-1:0];
                end
            end else begin
                mag_ff <= (mag_ff > i_decel) ? mag_ff - i_decel : '0;
            end
        end
    end
endmodule

// >>> verilog/dih_pkg.sv
// Types shared by the discrete input function handler
package dih_pkg;
    typedef enum logic [1:0] {
        DIH_ER_IDLE,
        DIH_ER_WAIT_STOP
    } dih_er_state_t;
    typedef logic signed [15:0] dih_vel_t;
endpackage

// >>> verilog/dih_scan_if.sv
// Scan tick and sampled flags passed between the handler's modules
`timescale 1ns/1ps
interface dih_scan_if;
    logic tick;
    logic [15:0] raw;
    logic [15:0] flags;
    modport src (output tick, output raw, input flags);
    modport filt (input tick, input raw, output flags);
endinterface

// >>> verilog/dih_top.sv
// Discrete input function handler: scan, dedicated functions, jog and outputs
`timescale 1ns/1ps
`include "dih_defs.svh"
module dih_top import dih_pkg::*; #(
    // Clocks per scan; only shortened for quick runs, the 1 ms default is the real period
    parameter int SCAN_CYCLES = `DIH_SCAN_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Pins, high while pulled to 24 V common
    input wire logic [`DIH_NUM_IN-1:0] i_in_pins,
    // Configuration
    input wire logic [`DIH_DB_W-1:0] i_debounce_ticks,
    input wire logic i_assign_enable,
    input wire logic i_assign_emerg,
    input wire logic i_assign_home_cmd,
    input wire logic i_assign_home_sw,
    input wire logic i_assign_jog,
    input wire logic i_home_sw_active_open,
    input wire logic i_prog_run_out_assigned,
    input wire logic [`DIH_NUM_OUT-1:0] i_out_default_en,
    input wire logic [`DIH_NUM_OUT-1:0] i_out_default_val,
    input wire logic [`DIH_VEL_W-1:0] i_jog_vel_param,
    input wire logic [`DIH_VEL_W-1:0] i_jog_acceleration,
    input wire logic [`DIH_VEL_W-1:0] i_jog_deceleration,
    // Program engine
    input wire logic [`DIH_NUM_OUT-1:0] i_prog_out_value,
    input wire logic i_prog_out_we,
    input wire logic i_enable_cmd,
    input wire logic i_disable_cmd,
    input wire logic i_prog_running,
    input wire logic i_prog_start,
    input wire logic i_motion_stopped,
    input wire logic i_jog_vel_we,
    input wire logic [`DIH_VEL_W-1:0] i_jog_vel_wdata,
    input wire logic i_cv_move_active,
    input wire logic i_cv_move_rev,
    input wire logic [3:0] i_test_sel,
    // Outputs
    output logic [`DIH_NUM_IN-1:0] o_input_flags,
    output logic o_test_result,
    output logic o_drive_enabled,
    output logic o_enable_seq,
    output logic o_disable_seq,
    output logic o_abort_prog,
    output logic o_start_prog,
    output logic [7:0] o_start_prog_num,
    output logic o_home_switch_active,
    output logic o_prog_running_out,
    output logic [`DIH_NUM_OUT-1:0] o_out_pull_low,
    output logic [`DIH_VEL_W-1:0] o_jog_velocity,
    output logic signed [`DIH_VEL_W:0] o_jog_cmd_vel,
    output logic o_cv_move_hold
);
    // ****************************************
    // Scan tick and pin synchroniser
    // ****************************************
    logic [16:0] scan_cnt_ff;
    logic tick_ff;
    logic [`DIH_NUM_IN-1:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
    dih_scan_if scan ();

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            scan_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (scan_cnt_ff == 17'(SCAN_CYCLES - 1)) begin
            scan_cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            scan_cnt_ff <= scan_cnt_ff + 17'h00001;
            tick_ff <= 1'b0;
        end
    end

    // Pin level high means pulled to common, i.e. ON (see R1)
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            pin_ff <= '0;
        end else begin
            sync1_ff <= i_in_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < `DIH_NUM_IN; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    assign scan.tick = tick_ff;
    assign scan.raw = pin_ff;

    // ****************************************
    // Flags; dedicated pins bypass filtering
    // ****************************************
    logic [`DIH_NUM_IN-1:0] bypass;
    always_comb begin
        // Unassigned functions leave pins general purpose (see R8)
        bypass = '0;
        bypass[`DIH_IDX_ENABLE] = i_assign_enable;
        bypass[`DIH_IDX_EMERG] = i_assign_emerg;
        bypass[`DIH_IDX_HOME_CMD] = i_assign_home_cmd;
        bypass[`DIH_IDX_HOME_SW] = i_assign_home_sw;
        bypass[`DIH_IDX_JOG_FWD] = i_assign_jog;
        bypass[`DIH_IDX_JOG_REV] = i_assign_jog;
    end

    dih_debounce u_db (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_bypass(bypass),
        .i_db_ticks(i_debounce_ticks),
        .scan(scan)
    );

    logic [`DIH_NUM_IN-1:0] flags;
    assign flags = scan.flags;
    // All sixteen flags stay readable whatever their assignment (see R3)
    assign o_input_flags = flags;

    logic test_ff;
    // Program tests read the flag, not the pin (see R5)
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            test_ff <= 1'b0;
        end else begin
            test_ff <= flags[i_test_sel];
        end
    end
    assign o_test_result = test_ff;

    // ****************************************
    // Edge detection on consecutive scans
    // ****************************************
    logic [`DIH_NUM_IN-1:0] prev_ff;
    logic tick_d_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prev_ff <= '0;
            tick_d_ff <= 1'b0;
        end else begin
            tick_d_ff <= tick_ff;
            if (tick_d_ff) begin
                prev_ff <= flags;
            end
        end
    end

    // One cycle after each tick the flags are fresh (see R24)
    function automatic logic rise(input logic [`DIH_NUM_IN-1:0] cur,
                                  input logic [`DIH_NUM_IN-1:0] prv, input int idx);
        rise = cur[idx] & ~prv[idx];
    endfunction

    logic en_rise, en_fall, er_rise, hc_rise;
    assign en_rise = tick_d_ff && i_assign_enable && rise(flags, prev_ff, `DIH_IDX_ENABLE);
    assign en_fall = tick_d_ff && i_assign_enable && rise(prev_ff, flags, `DIH_IDX_ENABLE);
    // Only rising edges are acted on (see R15)
    assign er_rise = tick_d_ff && i_assign_emerg && rise(flags, prev_ff, `DIH_IDX_EMERG);
    assign hc_rise = tick_d_ff && i_assign_home_cmd && rise(flags, prev_ff, `DIH_IDX_HOME_CMD);

    // ****************************************
    // Enable state
    // ****************************************
    logic enabled_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            // Enabled at power-up when no enable input is assigned (see R9)
            enabled_ff <= 1'b1;
        end else if (boot_ff && i_assign_enable) begin
            // An assigned enable input starts disabled and waits for its rising edge
            enabled_ff <= 1'b0;
        end else if (en_fall || i_disable_cmd) begin
            enabled_ff <= 1'b0;
        end else if (en_rise || i_enable_cmd) begin
            enabled_ff <= 1'b1;
        end
    end
    assign o_drive_enabled = enabled_ff;
    // Same sequences as the instructions (see R10) (see R11)
    assign o_enable_seq = en_rise;
    assign o_disable_seq = en_fall;

    // Power-up enable only applies when the input is unassigned (see R9)
    logic boot_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            boot_ff <= 1'b1;
        end else begin
            boot_ff <= 1'b0;
        end
    end

    // ****************************************
    // Emergency return sequence
    // ****************************************
    dih_er_state_t er_state_ff;
    logic er_start;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            er_state_ff <= DIH_ER_IDLE;
        end else begin
            unique case (er_state_ff)
                DIH_ER_IDLE: begin
                    if (er_rise) begin
                        er_state_ff <= DIH_ER_WAIT_STOP;
                    end
                end
                DIH_ER_WAIT_STOP: begin
                    if (i_motion_stopped) begin
                        er_state_ff <= DIH_ER_IDLE;
                    end
                end
                default: er_state_ff <= DIH_ER_IDLE;
            endcase
        end
    end
    // Abort first, start program 26 after standstill (see R14)
    assign er_start = (er_state_ff == DIH_ER_WAIT_STOP) && i_motion_stopped;

    // ****************************************
    // Program abort and start requests
    // ****************************************
    logic abort_ff, start_ff;
    logic [7:0] start_num_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            abort_ff <= 1'b0;
            start_ff <= 1'b0;
            start_num_ff <= 8'h00;
        end else begin
            abort_ff <= (en_fall || er_rise) && i_prog_running;
            start_ff <= 1'b0;
            if (er_start) begin
                start_ff <= 1'b1;
                start_num_ff <= `DIH_PROG_EMERG;
            end else if (hc_rise && !i_prog_running && er_state_ff == DIH_ER_IDLE) begin
                // Home rise ignored while a main program runs (see R16) (see R17)
                start_ff <= 1'b1;
                start_num_ff <= `DIH_PROG_HOME;
            end
        end
    end
    assign o_abort_prog = abort_ff;
    assign o_start_prog = start_ff;
    assign o_start_prog_num = start_num_ff;

    // Home switch polarity (see R18)
    assign o_home_switch_active = i_assign_home_sw &&
        (flags[`DIH_IDX_HOME_SW] ^ i_home_sw_active_open);

    // ****************************************
    // Outputs
    // ****************************************
    logic [`DIH_NUM_OUT-1:0] out_ff;
    logic prog_run_out_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            out_ff <= '0;
        end else if (en_fall && i_prog_running) begin
            // Program-end defaults on enable drop (see R12)
            out_ff <= (out_ff & ~i_out_default_en) | (i_out_default_val & i_out_default_en);
        end else if (i_prog_out_we) begin
            out_ff <= i_prog_out_value;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prog_run_out_ff <= 1'b0;
        end else if (en_fall) begin
            // Cleared on enable drop (see R13)
            prog_run_out_ff <= 1'b0;
        end else begin
            prog_run_out_ff <= i_prog_run_out_assigned && i_prog_running;
        end
    end
    assign o_prog_running_out = prog_run_out_ff;
    // High means the open collector pulls to common; low means float (see R2)
    assign o_out_pull_low = out_ff;

    // ****************************************
    // Jog
    // ****************************************
    logic [`DIH_VEL_W-1:0] jog_velocity_ff;
    logic cv_active_d_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            jog_velocity_ff <= '0;
            cv_active_d_ff <= 1'b0;
        end else begin
            cv_active_d_ff <= i_cv_move_active;
            if (i_prog_start || start_ff) begin
                // Program start clears jog velocity (see R20)
                jog_velocity_ff <= '0;
            end else if (i_jog_vel_we) begin
                jog_velocity_ff <= i_jog_vel_wdata;
            end else if (cv_active_d_ff && !i_cv_move_active || boot_ff) begin
                // Reload after a constant-velocity move ends (see R21)
                jog_velocity_ff <= i_jog_vel_param;
            end
        end
    end
    assign o_jog_velocity = jog_velocity_ff;

    logic jf, jr, jog_on, jog_rev_ff;
    logic [`DIH_VEL_W-1:0] jog_mag;
    assign jf = i_assign_jog && flags[`DIH_IDX_JOG_FWD];
    assign jr = i_assign_jog && flags[`DIH_IDX_JOG_REV];
    assign jog_on = (jf ^ jr) && enabled_ff;

    // Direction latched while held so the ramp down keeps its sign
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            jog_rev_ff <= 1'b0;
        end else if (jog_on && jog_mag == '0) begin
            jog_rev_ff <= jr;
        end
    end

    dih_jog_ramp u_ramp (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_ff),
        .i_run(jog_on && (jr == jog_rev_ff)),
        .i_dir_rev(jog_rev_ff),
        .i_speed(jog_velocity_ff),
        .i_accel(i_jog_acceleration),
        .i_decel(i_jog_deceleration),
        .o_mag(jog_mag)
    );

    // Forward is positive, reverse negative (see R19)
    assign o_jog_cmd_vel = jog_rev_ff ? -$signed({1'b0, jog_mag}) : $signed({1'b0, jog_mag});
    // Opposite jog holds the move at zero, release resumes (see R22)
    assign o_cv_move_hold = i_cv_move_active && jog_on && (jr != i_cv_move_rev);
endmodule
